// ==== logic/tef_pkg.sv ====
// Package with the register map, field positions and carriers of the timer event flag block.
`default_nettype none
package tef_pkg;
	localparam int tef_addr_w = 12;
	localparam logic [tef_addr_w-1:0] tef_off_enable = 12'h00c;
	localparam logic [tef_addr_w-1:0] tef_off_status = 12'h010;
	localparam logic [14:0] tef_enable_reset = 15'h0000;
	localparam logic [17:0] tef_status_reset = 18'h00000;
	localparam logic [31:0] tef_read_zero = 32'h00000000;

	// Enable register fields.
	localparam int tef_irq_lsb = 0;
	localparam int tef_irq_msb = 7;
	localparam int tef_update_dma_enable = 8;
	localparam int tef_ch_dma_lsb = 9;
	localparam int tef_commutation_dma_enable = 13;
	localparam int tef_trigger_dma_enable = 14;
	localparam int tef_enable_msb = 14;

	// Status register fields.
	localparam int tef_update_event_flag = 0;
	localparam int tef_ch_flag_lsb = 1;
	localparam int tef_commutation_event_flag = 5;
	localparam int tef_trigger_event_flag = 6;
	localparam int tef_break_event_flag = 7;
	localparam int tef_overcapture_lsb = 9;
	localparam int tef_ch56_flag_lsb = 16;
	localparam int tef_status_msb = 17;
	localparam int tef_channels = 6;
	localparam int tef_oc_channels = 4;

	// DMA request outputs, bit order.
	localparam int tef_dma_update = 0;
	localparam int tef_dma_ch_lsb = 1;
	localparam int tef_dma_commutation = 5;
	localparam int tef_dma_trigger = 6;
	localparam int tef_dma_w = 7;

	typedef struct packed {
		logic update_event;
		logic commutation_event;
		logic trigger_input;
		logic trigger_active_low;
		logic gated_mode;
		logic break_input;
		logic [tef_channels-1:0] capture_event;
		logic [tef_channels-1:0] input_mode;
		logic [tef_channels-1:0] capture_data_read;
	} tef_events_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [tef_addr_w-1:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} tef_apb_req_t;
endpackage : tef_pkg
`default_nettype wire

// ==== logic/tef_top.sv ====
// Event flags, interrupt and DMA request enables of the timer, with an APB slave.
//
// Local design decision: register access over APB.
`default_nettype none
module tef_top
	import tef_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire tef_apb_req_t apb,
	input wire tef_events_t events,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	output logic irq,
	output logic [tef_dma_w-1:0] dma_req
);
	logic [tef_enable_msb:0] enable;
	// Each flag lives in its own flip-flop; the status word is only a wired view of them.
	wire logic [tef_status_msb:0] status;
	logic update_flag;
	logic commutation_flag;
	logic trigger_flag;
	logic break_flag;
	logic trigger_prev;
	logic trigger_edge;
	logic hit_enable;
	logic hit_status;
	logic bus_done;
	logic wr_enable;
	logic wr_status;
	logic [tef_status_msb:0] clear_mask;
	logic [tef_status_msb:0] set_mask;

	// The slave answers one cycle into the access phase; read data is registered at the edge that raises pready, writes happen at the next edge.
	assign bus_done = apb.psel && apb.penable && pready;
	assign hit_enable = apb.paddr == tef_off_enable;
	assign hit_status = apb.paddr == tef_off_status;
	assign wr_enable = bus_done && apb.pwrite && hit_enable;
	assign wr_status = bus_done && apb.pwrite && hit_status;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= apb.psel && apb.penable && !pready;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= tef_read_zero;
			pslverr <= 1'b0;
		end else if (apb.psel && apb.penable && !pready) begin
			pslverr <= !(hit_enable || hit_status);
			if (apb.pwrite) begin
				prdata <= tef_read_zero;
			end else if (hit_enable) begin
				prdata <= {17'h00000, enable};
			end else if (hit_status) begin
				prdata <= {14'h0000, status};
			end else begin
				prdata <= tef_read_zero;
			end
		end
	end

	// Bit 15 is reserved and is not stored, so it always reads back as zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable <= tef_enable_reset;
		end else if (wr_enable) begin
			if (apb.pstrb[0]) begin
				enable[7:0] <= apb.pwdata[7:0];
			end
			if (apb.pstrb[1]) begin
				enable[tef_enable_msb:8] <= apb.pwdata[tef_enable_msb:8];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trigger_prev <= 1'b0;
		end else begin
			trigger_prev <= events.trigger_input;
		end
	end

	// In gated mode the counter follows the level, so both edges count as trigger events.
	always_comb begin
		if (events.gated_mode) begin
			trigger_edge = events.trigger_input ^ trigger_prev;
		end else if (events.trigger_active_low) begin
			trigger_edge = trigger_prev && !events.trigger_input;
		end else begin
			trigger_edge = events.trigger_input && !trigger_prev;
		end
	end

	// A zero written in an enabled byte lane clears the flag; reserved bits stay zero.
	always_comb begin
		clear_mask = '0;
		set_mask = '0;
		for (int b = 0; b <= tef_status_msb; b++) begin
			clear_mask[b] = wr_status && apb.pstrb[b/8] && !apb.pwdata[b];
		end
		set_mask[tef_update_event_flag] = events.update_event;
		set_mask[tef_commutation_event_flag] = events.commutation_event;
		set_mask[tef_trigger_event_flag] = trigger_edge;
		set_mask[tef_break_event_flag] = events.break_input;
	end

	// Hardware set beats a clear in the same cycle, so no event is lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			update_flag <= tef_status_reset[tef_update_event_flag];
		end else begin
			update_flag <= set_mask[tef_update_event_flag]
				|| (update_flag && !clear_mask[tef_update_event_flag]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			commutation_flag <= tef_status_reset[tef_commutation_event_flag];
		end else begin
			commutation_flag <= set_mask[tef_commutation_event_flag]
				|| (commutation_flag && !clear_mask[tef_commutation_event_flag]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trigger_flag <= tef_status_reset[tef_trigger_event_flag];
		end else begin
			trigger_flag <= set_mask[tef_trigger_event_flag]
				|| (trigger_flag && !clear_mask[tef_trigger_event_flag]);
		end
	end

	// A clear only sticks once the break input has gone inactive again.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			break_flag <= tef_status_reset[tef_break_event_flag];
		end else begin
			break_flag <= set_mask[tef_break_event_flag]
				|| (break_flag && !clear_mask[tef_break_event_flag]);
		end
	end

	assign status[tef_update_event_flag] = update_flag;
	assign status[tef_commutation_event_flag] = commutation_flag;
	assign status[tef_trigger_event_flag] = trigger_flag;
	assign status[tef_break_event_flag] = break_flag;

	// Reserved bits are not stored, so they read back as zero whatever software writes.
	assign status[tef_overcapture_lsb-1] = 1'b0;
	assign status[tef_ch56_flag_lsb-1:tef_overcapture_lsb+tef_oc_channels] = '0;

	for (genvar ch = 0; ch < tef_channels; ch++) begin : g_ch
		localparam int fb = (ch < tef_oc_channels) ? tef_ch_flag_lsb + ch
			: tef_ch56_flag_lsb + ch - tef_oc_channels;
		logic flag;
		assign status[fb] = flag;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				flag <= tef_status_reset[fb];
			end else if (events.capture_event[ch]) begin
				flag <= 1'b1;
			end else if (clear_mask[fb]) begin
				flag <= 1'b0;
			end else if (events.input_mode[ch] && events.capture_data_read[ch]) begin
				flag <= 1'b0;
			end
		end
		if (ch < tef_oc_channels) begin : g_oc
			localparam int ob = tef_overcapture_lsb + ch;
			logic oc_flag;
			assign status[ob] = oc_flag;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					oc_flag <= tef_status_reset[ob];
				end else if (events.input_mode[ch] && events.capture_event[ch] && flag) begin
					oc_flag <= 1'b1;
				end else if (clear_mask[ob]) begin
					oc_flag <= 1'b0;
				end
			end
		end
	end

	// The interrupt lags the flags by one cycle so that it comes straight from a flip-flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status[tef_irq_msb:tef_irq_lsb] & enable[tef_irq_msb:tef_irq_lsb]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_req <= '0;
		end else begin
			dma_req[tef_dma_update] <= events.update_event && enable[tef_update_dma_enable];
			dma_req[tef_dma_ch_lsb +: tef_oc_channels] <= events.capture_event[tef_oc_channels-1:0]
				& enable[tef_ch_dma_lsb +: tef_oc_channels];
			dma_req[tef_dma_commutation] <= events.commutation_event
				&& enable[tef_commutation_dma_enable];
			dma_req[tef_dma_trigger] <= trigger_edge && enable[tef_trigger_dma_enable];
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence wr_status_s(int bit_n);
		wr_status && apb.pstrb[bit_n/8] && !apb.pwdata[bit_n];
	endsequence
	sequence quiet_capture_s;
		!events.capture_event[0];
	endsequence

	trigger_dma_a: assert property (dma_req[tef_dma_trigger] |-> $past(enable[tef_trigger_dma_enable]))
		else $error("trigger DMA request without its enable");
	commutation_dma_a: assert property (events.commutation_event && enable[tef_commutation_dma_enable]
		|=> dma_req[tef_dma_commutation] ##1 !dma_req[tef_dma_commutation] || $past(events.commutation_event))
		else $error("commutation DMA request missing or stuck");
	channel_dma_a: assert property (dma_req[tef_dma_ch_lsb] == $past(events.capture_event[0]
		&& enable[tef_ch_dma_lsb]))
		else $error("channel 1 DMA request does not follow event and enable");
	update_dma_a: assert property (dma_req[tef_dma_update] |-> $past(events.update_event)
		&& $past(enable[tef_update_dma_enable]))
		else $error("update DMA request without event and enable");
	irq_gate_a: assert property (irq == $past(|(status[tef_irq_msb:0] & enable[tef_irq_msb:0])))
		else $error("interrupt does not match enabled flags");
	enable_write_a: assert property (wr_enable && apb.pstrb == 4'hf
		|=> enable == $past(apb.pwdata[tef_enable_msb:0]))
		else $error("enable register write not stored");
	overcapture_set_a: assert property (events.input_mode[0] && events.capture_event[0] && status[1]
		|=> status[tef_overcapture_lsb] ##1 status[tef_overcapture_lsb] || $past(clear_mask[9]))
		else $error("overcapture flag not set");
	flag_clear_a: assert property (wr_status_s(tef_overcapture_lsb) and quiet_capture_s
		|=> !status[tef_overcapture_lsb])
		else $error("overcapture flag not cleared by zero write");
	break_set_a: assert property (events.break_input |=> status[tef_break_event_flag])
		else $error("break flag not set while break input active");
	ch5_set_a: assert property (events.capture_event[4] |=> status[tef_ch56_flag_lsb] [*1])
		else $error("channel 5 flag not set on event");
	ch6_set_a: assert property (events.capture_event[5] |=> status[tef_status_msb])
		else $error("channel 6 flag not set on event");
	capture_set_a: assert property (events.capture_event[0] |=> status[tef_ch_flag_lsb])
		else $error("channel 1 flag not set on capture");
	data_read_clear_a: assert property (events.input_mode[0] && events.capture_data_read[0]
		&& !events.capture_event[0] |=> !status[tef_ch_flag_lsb])
		else $error("channel 1 flag not cleared by data read");
	oc4_set_a: assert property (events.input_mode[3] && events.capture_event[3]
		&& status[tef_ch_flag_lsb+3] |=> status[tef_overcapture_lsb+3])
		else $error("channel 4 overcapture flag not set");
	flag_keep_a: assert property (wr_status && apb.pstrb[0] && apb.pwdata[tef_commutation_event_flag]
		&& status[tef_commutation_event_flag] |=> status[tef_commutation_event_flag])
		else $error("writing one cleared a flag");
	trigger_flag_a: assert property (trigger_edge |=> status[tef_trigger_event_flag])
		else $error("trigger flag not set on trigger edge");
	gated_edge_a: assert property (events.gated_mode && (events.trigger_input != trigger_prev)
		|=> status[tef_trigger_event_flag])
		else $error("trigger flag not set on gated edge");

	// Each of the update, channel 1, commutation, trigger and break sources alone must be able to raise the line when enabled.
	update_irq_a: assert property (status[tef_update_event_flag] && enable[tef_irq_lsb]
		|=> irq)
		else $error("update interrupt missing");
	channel_irq_a: assert property (status[tef_ch_flag_lsb] && enable[tef_ch_flag_lsb]
		|=> irq)
		else $error("channel 1 interrupt missing");
	comm_irq_a: assert property (status[tef_commutation_event_flag]
		&& enable[tef_commutation_event_flag] |=> irq)
		else $error("commutation interrupt missing");
	trigger_irq_a: assert property (status[tef_trigger_event_flag]
		&& enable[tef_trigger_event_flag] |=> irq)
		else $error("trigger interrupt missing");
	break_irq_a: assert property (status[tef_break_event_flag] && enable[tef_irq_msb]
		|=> irq)
		else $error("break interrupt missing");
	irq_mask_a: assert property (enable[tef_irq_msb:tef_irq_lsb] == '0 |=> !irq)
		else $error("interrupt raised with every source disabled");

	// The bus answer is a single-cycle pulse even if the master lingers.
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held for more than one cycle");
endmodule : tef_top
`default_nettype wire

// ==== verif/tef_req_sink.sv ====
// Interrupt and DMA controller model that counts the DMA requests the block raises and latches any interrupt.
`default_nettype none
module tef_req_sink
	import tef_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic irq,
	input wire logic [tef_dma_w-1:0] dma_req,
	output logic [31:0] dma_count,
	output logic irq_seen
);
	timeunit 1ns;
	timeprecision 1ps;
	// Each request bit is a one-cycle pulse, so every high bit at an edge is one transfer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_count <= 32'h00000000;
		end else begin
			dma_count <= dma_count + 32'($countones(dma_req));
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_seen <= 1'b0;
		end else begin
			irq_seen <= irq_seen | irq;
		end
	end
endmodule : tef_req_sink
`default_nettype wire

// ==== verif/timer_event_flag_and_request_enables_tb.sv ====
// Register and event sequence bench for the timer event flag block.
`default_nettype none
module timer_event_flag_and_request_enables_tb;
	import tef_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	tef_apb_req_t apb = '0;
	tef_events_t ev = '0;
	logic pready, pslverr, irq, irq_seen;
	logic [31:0] prdata, dma_count, rd;
	logic [tef_dma_w-1:0] dma_req;
	logic err;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	always #12.5 pclk = ~pclk;
	tef_top dut (.pclk(pclk), .presetn(presetn), .apb(apb), .events(ev), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .irq(irq), .dma_req(dma_req));
	tef_req_sink sink (.pclk(pclk), .presetn(presetn), .irq(irq), .dma_req(dma_req),
		.dma_count(dma_count), .irq_seen(irq_seen));
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			wrap_up();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: 4'hf};
		@(posedge pclk);
		apb.penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		apb <= '0;
	endtask : xfer
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
		xfer(1'b0, a, 32'h00000000);
		chk(what, exp, rd);
	endtask : rchk
	// Every event source fires in one cycle; the trigger makes a single rising edge.
	task automatic fire;
		@(posedge pclk);
		ev.update_event <= 1'b1;
		ev.commutation_event <= 1'b1;
		ev.capture_event <= 6'h3f;
		ev.break_input <= 1'b1;
		ev.trigger_input <= 1'b1;
		@(posedge pclk);
		ev.update_event <= 1'b0;
		ev.commutation_event <= 1'b0;
		ev.capture_event <= 6'h00;
		ev.break_input <= 1'b0;
		ev.trigger_input <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : fire
	initial begin
		ev.input_mode = 6'h3f;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rchk(tef_off_enable, 32'h00000000, "enable reset");
		rchk(tef_off_status, 32'h00000000, "status reset");
		$display("test reset done");
		fire();
		rchk(tef_off_status, 32'h000300ff, "flags set");
		chk("no dma", 32'h00000000, dma_count);
		chk("no irq", 32'h00000000, {31'h0, irq});
		fire();
		rchk(tef_off_status, 32'h00031eff, "overcapture");
		$display("test flags done");
		xfer(1'b1, tef_off_enable, 32'h0000ffff);
		rchk(tef_off_enable, 32'h00007fff, "enable rw");
		chk("irq on", 32'h00000001, {31'h0, irq});
		chk("irq seen", 32'h00000001, {31'h0, irq_seen});
		xfer(1'b1, tef_off_status, 32'h00031efe);
		rchk(tef_off_status, 32'h00031efe, "clear one");
		@(posedge pclk);
		ev.capture_data_read <= 6'h01;
		@(posedge pclk);
		ev.capture_data_read <= 6'h00;
		rchk(tef_off_status, 32'h00031efc, "data read");
		xfer(1'b1, tef_off_status, 32'h00000000);
		rchk(tef_off_status, 32'h00000000, "clear all");
		chk("irq off", 32'h00000000, {31'h0, irq});
		$display("test clear done");
		xfer(1'b1, tef_off_enable, 32'h00007f00);
		fire();
		chk("dma count", 32'h00000007, dma_count);
		chk("irq masked", 32'h00000000, {31'h0, irq});
		rchk(12'h020, 32'h00000000, "unmapped data");
		chk("unmapped err", 32'h00000001, {31'h0, err});
		$display("test dma done");
		@(posedge pclk);
		ev.gated_mode <= 1'b1;
		ev.trigger_input <= 1'b1;
		xfer(1'b1, tef_off_status, 32'h00000000);
		@(posedge pclk);
		ev.trigger_input <= 1'b0;
		repeat (2) @(posedge pclk);
		rchk(tef_off_status, 32'h00000040, "gated edge");
		chk("gated dma", 32'h00000009, dma_count);
		$display("test gated done");
		wrap_up();
	end
endmodule : timer_event_flag_and_request_enables_tb
`default_nettype wire
